/* File: logic/dsg_map.vh */
// constants for the device status event group
// Notes on behaviour
// - condition word follows live hardware states
// - bits 1,2 show probe attached per channel
// - bits 3,4 show channel error per channel
// - bits 5,6 show shape calibration table use
// - bit 13 shows a key press
// - condition read returns value, changes nothing
// - enabled rising condition edge sets event bit
// - enabled falling condition edge sets event bit
// - event bits stay set until read
// - event read returns contents then clears
// - summary high when enabled event bit set
// - masks writable with any value, read back
// - preset: enable zero, rising all, falling zero
`ifndef DSG_MAP_VH
`define DSG_MAP_VH

// ----------------------------------------------------------------
// register selectors on the command port
// ----------------------------------------------------------------
`define DSG_SEL_CONDITION 3'h0
`define DSG_SEL_ENABLE 3'h1
`define DSG_SEL_EVENTS 3'h2
`define DSG_SEL_FALLING 3'h3
`define DSG_SEL_RISING 3'h4

// ----------------------------------------------------------------
// condition word bit positions
// ----------------------------------------------------------------
`define DSG_BIT_PROBE1 1
`define DSG_BIT_PROBE2 2
`define DSG_BIT_ERROR1 3
`define DSG_BIT_ERROR2 4
`define DSG_BIT_SHAPE1 5
`define DSG_BIT_SHAPE2 6
`define DSG_BIT_KEY 13
`define DSG_USED_MASK 16'h207e

// ----------------------------------------------------------------
// reset and preset values
// ----------------------------------------------------------------
`define DSG_ENABLE_RESET 16'h0000
`define DSG_RISING_RESET 16'hffff
`define DSG_FALLING_RESET 16'h0000
`define DSG_WORD_ZERO 16'h0000

`endif

/* File: logic/dsg_sync2.v */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps

module dsg_sync2 #(
  parameter WIDTH = 7
) (
  input wire ref_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule // dsg_sync2

/* File: logic/dsg_status_group.v */
// device status event group: condition, transition filters, events, summary
`timescale 1ns/1ps
`include "dsg_map.vh"

module dsg_status_group #(
  parameter WORD_W = 16
) (
  input wire ref_clk,
  input wire rst,
  input wire [1:0] probe_present,
  input wire [1:0] chan_error,
  input wire [1:0] shape_cal_active,
  input wire key_pressed,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [2:0] cmd_sel,
  input wire [WORD_W-1:0] cmd_wdata,
  input wire preset,
  output reg rsp_valid,
  output reg [WORD_W-1:0] rsp_data,
  output reg rsp_err,
  output reg summary_out,
  output reg [WORD_W-1:0] condition_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // pin bundle positions
  localparam PIN_W = 7;
  localparam PIN_PROBE1 = 0;
  localparam PIN_PROBE2 = 1;
  localparam PIN_ERROR1 = 2;
  localparam PIN_ERROR2 = 3;
  localparam PIN_SHAPE1 = 4;
  localparam PIN_SHAPE2 = 5;
  localparam PIN_KEY = 6;

  wire [PIN_W-1:0] pin_raw;
  wire [PIN_W-1:0] pin_sync;
  reg [WORD_W-1:0] cond_next;
  reg [WORD_W-1:0] cond_reg;
  reg [WORD_W-1:0] prev_cond_reg;
  wire [WORD_W-1:0] rise;
  wire [WORD_W-1:0] fall;
  wire [WORD_W-1:0] hit;
  wire [WORD_W-1:0] used_mask;
  reg [WORD_W-1:0] enable_reg;
  reg [WORD_W-1:0] enable_next;
  reg [WORD_W-1:0] rising_reg;
  reg [WORD_W-1:0] rising_next;
  reg [WORD_W-1:0] falling_reg;
  reg [WORD_W-1:0] falling_next;
  reg [WORD_W-1:0] event_reg;
  wire [WORD_W-1:0] event_next;
  wire rd_event;
  wire wr_enable;
  wire wr_rising;
  wire wr_falling;
  reg [WORD_W-1:0] rsp_data_next;
  reg rsp_err_next;
  reg summary_next;

  assign used_mask = `DSG_USED_MASK;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  assign pin_raw = {key_pressed, shape_cal_active, chan_error, probe_present};

  dsg_sync2 #(
    .WIDTH(PIN_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(pin_raw),
    .sync_out(pin_sync)
  );

  // ----------------------------------------------------------------
  // condition word assembly
  // ----------------------------------------------------------------
  always @* begin
    cond_next = `DSG_WORD_ZERO;
    cond_next[`DSG_BIT_PROBE1] = pin_sync[PIN_PROBE1];
    cond_next[`DSG_BIT_PROBE2] = pin_sync[PIN_PROBE2];
    cond_next[`DSG_BIT_ERROR1] = pin_sync[PIN_ERROR1];
    cond_next[`DSG_BIT_ERROR2] = pin_sync[PIN_ERROR2];
    cond_next[`DSG_BIT_SHAPE1] = pin_sync[PIN_SHAPE1];
    cond_next[`DSG_BIT_SHAPE2] = pin_sync[PIN_SHAPE2];
    cond_next[`DSG_BIT_KEY] = pin_sync[PIN_KEY];
  end

  // live tracking, no latching
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cond_reg <= `DSG_WORD_ZERO;
    end else begin
      cond_reg <= cond_next;
    end
  end

  // ----------------------------------------------------------------
  // previous condition sample for edge detection
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_cond_reg <= `DSG_WORD_ZERO;
    end else begin
      prev_cond_reg <= cond_reg;
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign rd_event = cmd_valid & ~cmd_write & (cmd_sel == `DSG_SEL_EVENTS);
  assign wr_enable = cmd_valid & cmd_write & (cmd_sel == `DSG_SEL_ENABLE);
  assign wr_rising = cmd_valid & cmd_write & (cmd_sel == `DSG_SEL_RISING);
  assign wr_falling = cmd_valid & cmd_write & (cmd_sel == `DSG_SEL_FALLING);

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  always @* begin
    enable_next = enable_reg;
    if (preset) begin
      enable_next = `DSG_ENABLE_RESET;
    end else if (wr_enable) begin
      enable_next = cmd_wdata;
    end
  end

  always @* begin
    rising_next = rising_reg;
    if (preset) begin
      rising_next = `DSG_RISING_RESET;
    end else if (wr_rising) begin
      rising_next = cmd_wdata;
    end
  end

  always @* begin
    falling_next = falling_reg;
    if (preset) begin
      falling_next = `DSG_FALLING_RESET;
    end else if (wr_falling) begin
      falling_next = cmd_wdata;
    end
  end

  // enable mask
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= `DSG_ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // rising edge mask
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rising_reg <= `DSG_RISING_RESET;
    end else begin
      rising_reg <= rising_next;
    end
  end

  // falling edge mask
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      falling_reg <= `DSG_FALLING_RESET;
    end else begin
      falling_reg <= falling_next;
    end
  end

  // ----------------------------------------------------------------
  // transition filters and sticky events
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WORD_W; i = i + 1) begin : g_evt
      assign rise[i] = cond_reg[i] & ~prev_cond_reg[i];
      assign fall[i] = ~cond_reg[i] & prev_cond_reg[i];
      assign hit[i] = used_mask[i] & ((rising_reg[i] & rise[i]) | (falling_reg[i] & fall[i]));
      // set wins over the read clear
      assign event_next[i] = used_mask[i] & ((event_reg[i] & ~rd_event) | hit[i]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // event register
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_reg <= `DSG_WORD_ZERO;
    end else begin
      event_reg <= event_next;
    end
  end

  // ----------------------------------------------------------------
  // summary bit
  // ----------------------------------------------------------------
  always @* begin
    summary_next = |(enable_next & event_next);
  end

  // ----------------------------------------------------------------
  // read answers
  // ----------------------------------------------------------------
  always @* begin
    rsp_data_next = `DSG_WORD_ZERO;
    rsp_err_next = 1'b0;
    if (cmd_write) begin
      if (cmd_sel == `DSG_SEL_ENABLE) begin
        rsp_err_next = 1'b0;
      end else if (cmd_sel == `DSG_SEL_RISING) begin
        rsp_err_next = 1'b0;
      end else if (cmd_sel == `DSG_SEL_FALLING) begin
        rsp_err_next = 1'b0;
      end else begin
        rsp_err_next = 1'b1;
      end
    end else begin
      if (cmd_sel == `DSG_SEL_CONDITION) begin
        rsp_data_next = cond_reg;
      end else if (cmd_sel == `DSG_SEL_ENABLE) begin
        rsp_data_next = enable_reg;
      end else if (cmd_sel == `DSG_SEL_EVENTS) begin
        rsp_data_next = event_reg;
      end else if (cmd_sel == `DSG_SEL_FALLING) begin
        rsp_data_next = falling_reg;
      end else if (cmd_sel == `DSG_SEL_RISING) begin
        rsp_data_next = rising_reg;
      end else begin
        rsp_err_next = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // answer strobe
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
    end
  end

  // ----------------------------------------------------------------
  // answer data, zero outside answers
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_data <= `DSG_WORD_ZERO;
    end else if (cmd_valid) begin
      rsp_data <= rsp_data_next;
    end else begin
      rsp_data <= `DSG_WORD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // refusal flag, only with an answer
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_err <= 1'b0;
    end else if (cmd_valid) begin
      rsp_err <= rsp_err_next;
    end else begin
      rsp_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // summary output
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      summary_out <= 1'b0;
    end else begin
      summary_out <= summary_next;
    end
  end

  // ----------------------------------------------------------------
  // condition word output
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      condition_out <= `DSG_WORD_ZERO;
    end else begin
      condition_out <= cond_reg;
    end
  end

endmodule // dsg_status_group

/* File: bench/dsg_host.sv */
// remote host model issuing register commands
`timescale 1ns/1ps
module dsg_host (
  input wire ref_clk,
  output reg cmd_valid = 1'b0,
  output reg cmd_write = 1'b0,
  output reg [2:0] cmd_sel = 3'h0,
  output reg [15:0] cmd_wdata = 16'h0000,
  input wire rsp_valid,
  input wire [15:0] rsp_data,
  input wire rsp_err
);
  // one-cycle strobe, answer taken a cycle later, data inverted once released
  task xfer(input w, input [2:0] s, input [15:0] d, output [15:0] q, output e, output ok);
    @(negedge ref_clk);
    {cmd_valid, cmd_write, cmd_sel, cmd_wdata} = {1'b1, w, s, d};
    @(negedge ref_clk);
    {ok, q, e} = {rsp_valid, rsp_data, rsp_err};
    {cmd_valid, cmd_wdata} = {1'b0, ~d};
  endtask
endmodule // dsg_host

/* File: bench/dsg_status_group_chk.sv */
// port checker for the status group
`timescale 1ns/1ps
`include "dsg_map.vh"
module dsg_chk #(
  parameter WORD_W = 16
) (
  input wire ref_clk,
  input wire rst,
  input wire [1:0] probe_present,
  input wire [1:0] chan_error,
  input wire [1:0] shape_cal_active,
  input wire key_pressed,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [2:0] cmd_sel,
  input wire [WORD_W-1:0] cmd_wdata,
  input wire preset,
  input wire rsp_valid,
  input wire [WORD_W-1:0] rsp_data,
  input wire rsp_err,
  input wire summary_out,
  input wire [WORD_W-1:0] condition_out
);
  wire bad_cmd = cmd_sel > 3'h4 || cmd_write && (cmd_sel == 3'h0 || cmd_sel == 3'h2);
  wire [15:0] pin_word = {2'b00, key_pressed, 6'h00, shape_cal_active, chan_error, probe_present, 1'b0};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ans; cmd_valid |=> rsp_valid; endproperty
  a_ans: assert property (p_ans) else $error("command not answered");
  property p_quiet; !cmd_valid |=> !rsp_valid && rsp_data == 16'h0000 && !rsp_err; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without command");
  property p_refuse; cmd_valid |=> rsp_err == $past(bad_cmd); endproperty
  a_refuse: assert property (p_refuse) else $error("wrong refusal flag");
  property p_unused; (condition_out & ~`DSG_USED_MASK) == 16'h0000; endproperty
  a_unused: assert property (p_unused) else $error("unused condition bit set");
  property p_cread; cmd_valid && !cmd_write && cmd_sel == 3'h0 |=> (rsp_data & ~`DSG_USED_MASK) == 0; endproperty
  a_cread: assert property (p_cread) else $error("unused bit in condition read");
  property p_pins; $stable(pin_word) [*5] |-> condition_out == pin_word; endproperty
  a_pins: assert property (p_pins) else $error("condition not following pins");
  property p_preset; preset |=> !summary_out; endproperty
  a_preset: assert property (p_preset) else $error("summary after preset");
  property p_noen; cmd_valid && cmd_write && cmd_sel == 3'h1 && cmd_wdata == 16'h0000 && !preset |=> !summary_out;
  endproperty
  a_noen: assert property (p_noen) else $error("summary with empty enable");
  c_events: cover property (rsp_valid && rsp_data != 16'h0000);
  c_sum: cover property ($rose(summary_out));
  c_err: cover property (rsp_err);
endmodule // dsg_chk
bind dsg_status_group dsg_chk #(.WORD_W(WORD_W)) u_chk (.*);

/* File: bench/dsg_status_group_test.sv */
// self-checking bench for the device status event group
`timescale 1ns/1ps
module device_status_event_group_test;
  reg ref_clk = 1'b0, rst = 1'b1, preset = 1'b0, key_pressed = 1'b0;
  reg [1:0] probe_present = 2'h0, chan_error = 2'h0, shape_cal_active = 2'h0;
  wire cmd_valid, cmd_write, rsp_valid, rsp_err, summary_out;
  wire [2:0] cmd_sel;
  wire [15:0] cmd_wdata, rsp_data, condition_out;
  integer bad_count = 0, comparisons = 0, i, j;
  reg [31:0] seed = 32'hfb5b0bc4;
  reg [15:0] q, d, n, old = 16'h0000, ev = 16'h0000, rise, fall, en;
  reg [2:0] s;
  reg e, ok;
  dsg_status_group u_dut (.*);
  dsg_host u_host (.*);
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task check(input [15:0] x, input [15:0] g, input [63:0] what);
    comparisons = comparisons + 1;
    if (g !== x) begin
      bad_count = bad_count + 1;
      $display("unexpected %0s: expected %h seen %h", what, x, g);
    end
  endtask
  task cmd(input w, input [2:0] c, input [15:0] v);
    u_host.xfer(w, c, v, q, e, ok);
    check(16'h0001, {15'h0000, ok}, "answer");
  endtask
  task pin(input [6:0] p);
    n = {2'b00, p[6], 6'h00, p[5:0], 1'b0};
    ev = ev | (rise & ~old & n) | (fall & old & ~n);
    old = n;
    @(negedge ref_clk);
    {key_pressed, shape_cal_active, chan_error, probe_present} = p;
    repeat (5) @(negedge ref_clk);
  endtask
  task defaults;
    for (i = 0; i < 5; i = i + 1) begin
      cmd(1'b0, i[2:0], 16'h0000);
      check((i == 4) ? 16'hffff : 16'h0000, q, "default");
    end
  endtask
  task wrap_up;
    $display("counts: %0d compared, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count = bad_count + 1;
    wrap_up;
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    defaults;
    $display("test reset done");
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(seed);
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : seed[15:0];
      s = 3'((i % 3 == 0) ? 1 : 2 + i % 3);
      cmd(1'b1, s, d);
      cmd(1'b0, s, 16'h0000);
      check(d, q, "mask");
    end
    @(negedge ref_clk);
    preset = 1'b1;
    @(negedge ref_clk);
    preset = 1'b0;
    defaults;
    $display("test masks done");
    for (j = 0; j < 6; j = j + 1) begin
      seed = lfsr(seed);
      rise = (j == 0) ? 16'hffff : (j == 1) ? 16'h0000 : seed[15:0];
      fall = (j == 1) ? 16'hffff : (j == 0) ? 16'h0000 : seed[31:16];
      en = {seed[7:0], seed[31:24]};
      cmd(1'b1, 3'h4, rise);
      cmd(1'b1, 3'h3, fall);
      cmd(1'b1, 3'h1, en);
      for (i = 0; i < 3; i = i + 1) begin
        seed = lfsr(seed);
        pin(seed[6:0]);
      end
      check({15'h0000, |(ev & en)}, {15'h0000, summary_out}, "summary");
      cmd(1'b0, 3'h0, 16'h0000);
      check(old, q, "cond");
      cmd(1'b0, 3'h2, 16'h0000);
      check(ev, q, "events");
      ev = 16'h0000;
      cmd(1'b0, 3'h2, 16'h0000);
      check(16'h0000, q, "cleared");
    end
    $display("test events done");
    for (i = 0; i < 5; i = i + 1) begin
      s = 3'(15'h7d50 >> (3 * i));
      cmd(i < 2, s, 16'hffff);
      check(16'h0001, {15'h0000, e}, "refused");
    end
    cmd(1'b0, 3'h0, 16'h0000);
    check(old, q, "cond");
    $display("test refusals done");
    wrap_up;
  end
endmodule // device_status_event_group_test
